// ===== logic/asr_serial_rx_dma.sv
// Serial receiver and transmitter with one DMA channel, Wishbone register slave
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Good frame with holding empty moves shift register to holding
// - Good frame raises receive-full request
// - Eight-bit read-only holding forms double buffer
// - Empty transmit shifter loads transmit holding register
// - Status flags: software may only clear
// - Frame: 8 data, no parity, 1 stop, LSB first
// - Baud generator defaults to 38400 bps
// - Each receive-full request starts one DMA transfer
// - Source pointer not updated by transfers, software writes only
// - Destination pointer updated after every transfer
// - Count starts 128, decrements each transfer
// - Reception waits for start trigger high
// - Eight-bit divisor sets bit rate
// - Format register selects baud clock prescale 4^n, frame fixed
// - Card mode register selects normal mode
// - DMA completion clears receive-full flag
// - Source stays fixed, destination increments
module asr_serial_rx_dma
  import asr_pkg::*;
(
  // Clock and reset
  input  wire  logic        sys_clk_in,
  input  wire  logic        sys_rst_in,
  // Wishbone classic slave
  input  wire  logic        wb_cyc_in,
  input  wire  logic        wb_stb_in,
  input  wire  logic        wb_we_in,
  input  wire  logic [7:0]  wb_adr_in,
  input  wire  logic [3:0]  wb_sel_in,
  input  wire  logic [31:0] wb_dat_in,
  output var   logic [31:0] wb_dat_out,
  output var   logic        wb_ack_out,
  // Serial pins
  input  wire  logic        serial_in_pin_in,
  input  wire  logic        start_trigger_pin_in,
  output var   logic        serial_out_pin_out,
  // Requests
  output var   logic        rx_full_request_out,
  output var   logic        rx_error_request_out,
  output var   logic        dma_end_out,
  // DMA memory write port
  output var   asr_dma_wr_t dma_wr_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]    rx_data_holding_r;
  logic [7:0]    tx_data_holding_r;
  logic [7:0]    serial_format_select_r;
  logic [7:0]    baud_divisor_r;
  logic [7:0]    serial_control_reg_r;
  logic [7:0]    card_mode_reg_r;
  logic [31:0]   dma_source_pointer_r;
  logic [31:0]   dma_destination_pointer_r;
  logic [31:0]   dma_remaining_count_r;
  logic          dma_channel_enable_r;
  logic          dma_end_flag_r;
  logic          tx_empty_flag_r;
  logic          rx_full_flag_r;
  logic          overrun_flag_r;
  logic          framing_error_flag_r;
  logic          trigger_seen_r;
  logic          ack_r;
  logic [31:0]   rd_data_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire bus_req   = wb_cyc_in && wb_stb_in;
  wire bus_wr    = bus_req && wb_we_in && ack_r;
  wire sel_lo    = wb_sel_in[0];
  wire wr_tx     = bus_wr && sel_lo && (wb_adr_in == OFS_TX_DATA);
  wire wr_fmt    = bus_wr && sel_lo && (wb_adr_in == OFS_FORMAT);
  wire wr_baud   = bus_wr && sel_lo && (wb_adr_in == OFS_BAUD);
  wire wr_ctl    = bus_wr && sel_lo && (wb_adr_in == OFS_CONTROL);
  wire wr_flags  = bus_wr && sel_lo && (wb_adr_in == OFS_FLAGS);
  wire wr_card   = bus_wr && sel_lo && (wb_adr_in == OFS_CARD);
  wire wr_src    = bus_wr && (wb_adr_in == OFS_DMA_SRC);
  wire wr_dst    = bus_wr && (wb_adr_in == OFS_DMA_DST);
  wire wr_cnt    = bus_wr && (wb_adr_in == OFS_DMA_CNT);
  wire wr_mode   = bus_wr && sel_lo && (wb_adr_in == OFS_DMA_MODE);

  // Card mode bit forces the receiver idle and blocks transmit loads: only normal mode exists here
  wire normal_mode = !card_mode_reg_r[CARD_SMART];
  wire rx_enable   = serial_control_reg_r[CTL_RX_EN] && normal_mode;
  wire tx_enable   = serial_control_reg_r[CTL_TX_EN] && normal_mode;
  wire rx_running  = rx_enable && trigger_seen_r;

  wire [7:0] flag_byte = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r,
                          framing_error_flag_r, 1'b0, 3'h0};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_in)
      OFS_RX_DATA:  rd_mux = {24'h000000, rx_data_holding_r};
      OFS_TX_DATA:  rd_mux = {24'h000000, tx_data_holding_r};
      OFS_FORMAT:   rd_mux = {24'h000000, serial_format_select_r};
      OFS_BAUD:     rd_mux = {24'h000000, baud_divisor_r};
      OFS_CONTROL:  rd_mux = {24'h000000, serial_control_reg_r};
      OFS_FLAGS:    rd_mux = {24'h000000, flag_byte};
      OFS_CARD:     rd_mux = {24'h000000, card_mode_reg_r};
      OFS_DMA_SRC:  rd_mux = dma_source_pointer_r;
      OFS_DMA_DST:  rd_mux = dma_destination_pointer_r;
      OFS_DMA_CNT:  rd_mux = dma_remaining_count_r;
      OFS_DMA_MODE: rd_mux = {30'h00000000, dma_end_flag_r, dma_channel_enable_r};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ack_r     <= 1'b0;
      rd_data_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req && !ack_r;
      if (bus_req && !ack_r) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rd_data_r;

  // ----------------------------------------------------------------
  // Baud tick: divisor plus prescale 4^n from the format register
  // ----------------------------------------------------------------
  logic [5:0] pre_cnt_r;
  logic [7:0] baud_cnt_r;
  logic [5:0] pre_limit;
  always_comb begin
    case (serial_format_select_r[FMT_PRESCALE_LO +: 2])
      2'h0:    pre_limit = 6'h00;
      2'h1:    pre_limit = 6'h03;
      2'h2:    pre_limit = 6'h0F;
      default: pre_limit = 6'h3F;
    endcase
  end
  wire pre_tick  = (pre_cnt_r == pre_limit);
  wire baud_tick = pre_tick && (baud_cnt_r == baud_divisor_r);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || wr_baud || wr_fmt) begin
      pre_cnt_r  <= 6'h00;
      baud_cnt_r <= 8'h00;
    end else begin
      pre_cnt_r <= pre_tick ? 6'h00 : pre_cnt_r + 6'h01;
      if (pre_tick) begin
        baud_cnt_r <= (baud_cnt_r == baud_divisor_r) ? 8'h00 : baud_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver, 16x oversampled, sampled at mid bit
  // ----------------------------------------------------------------
  asr_rx_state_t rx_state_r;
  logic [3:0]    rx_tick_r;
  logic [3:0]    rx_bit_r;
  logic [7:0]    rx_shift_reg_r;
  wire rx_sample = baud_tick && (rx_tick_r == LAST_TICK);
  wire rx_mid    = baud_tick && (rx_tick_r == MID_TICK);
  wire rx_done   = (rx_state_r == RX_STOP) && rx_sample;
  wire stop_ok   = serial_in_pin_in;
  wire rx_good   = rx_done && stop_ok && !rx_full_flag_r;
  wire rx_over   = rx_done && stop_ok && rx_full_flag_r;
  wire rx_frame  = rx_done && !stop_ok;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !rx_running) begin
      rx_state_r     <= RX_IDLE;
      rx_tick_r      <= 4'h0;
      rx_bit_r       <= 4'h0;
      rx_shift_reg_r <= 8'h00;
    end else if (baud_tick) begin
      rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_state_r)
        RX_IDLE: begin
          rx_tick_r <= 4'h0;
          if (!serial_in_pin_in) begin
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_tick_r  <= 4'h0;
            rx_bit_r   <= 4'h0;
            rx_state_r <= serial_in_pin_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shift_reg_r <= {serial_in_pin_in, rx_shift_reg_r[7:1]};
            rx_bit_r       <= rx_bit_r + 4'h1;
            if (rx_bit_r == DATA_BITS - 4'h1) begin
              rx_state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DMA channel: one byte per receive-full, fixed source
  // ----------------------------------------------------------------
  wire dma_go = dma_channel_enable_r && rx_full_request_out
                && (dma_remaining_count_r != 32'h00000000)
                && !dma_wr_out.valid;
  wire dma_xfer = dma_wr_out.valid;
  wire dma_last = dma_xfer && (dma_remaining_count_r == 32'h00000001);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      dma_wr_out                <= '0;
      dma_source_pointer_r      <= 32'h00000000;
      dma_destination_pointer_r <= 32'h00000000;
      dma_remaining_count_r     <= DMA_CNT_RESET;
      dma_channel_enable_r      <= 1'b0;
      dma_end_flag_r            <= 1'b0;
    end else begin
      dma_wr_out.valid <= dma_go;
      if (dma_go) begin
        dma_wr_out.addr <= dma_destination_pointer_r;
        dma_wr_out.data <= rx_data_holding_r;
      end
      if (wr_src) begin
        dma_source_pointer_r <= merge(dma_source_pointer_r, wb_dat_in, wb_sel_in);
      end
      // Source is the holding register itself: the update step is zero
      if (wr_dst) begin
        dma_destination_pointer_r <= merge(dma_destination_pointer_r, wb_dat_in, wb_sel_in);
      end else if (dma_xfer) begin
        dma_destination_pointer_r <= dma_destination_pointer_r + DMA_DST_STEP;
      end
      if (wr_cnt) begin
        dma_remaining_count_r <= merge(dma_remaining_count_r, wb_dat_in, wb_sel_in);
      end else if (dma_xfer) begin
        dma_remaining_count_r <= dma_remaining_count_r - 32'h00000001;
      end
      if (dma_last) begin
        dma_channel_enable_r <= 1'b0;
      end else if (wr_mode) begin
        dma_channel_enable_r <= wb_dat_in[DMA_ENABLE];
      end
      if (dma_last) begin
        dma_end_flag_r <= 1'b1;
      end else if (wr_mode && !wb_dat_in[DMA_END]) begin
        dma_end_flag_r <= 1'b0;
      end
    end
  end
  // Source pointer is written by software only; fixed mode keeps it

  assign dma_end_out = dma_end_flag_r;

  // ----------------------------------------------------------------
  // Flags: hardware set wins over any software clear in the same cycle
  // ----------------------------------------------------------------
  logic tx_idle;
  wire tx_load = tx_enable && !tx_empty_flag_r && tx_idle;
  wire clr_rx_full = (wr_flags && !wb_dat_in[FLG_RX_FULL]) || dma_xfer;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_data_holding_r      <= 8'h00;
      tx_data_holding_r      <= 8'h00;
      serial_format_select_r <= 8'h00;
      baud_divisor_r         <= BAUD_RESET;
      serial_control_reg_r   <= 8'h00;
      card_mode_reg_r        <= 8'h00;
      tx_empty_flag_r        <= 1'b1;
      rx_full_flag_r         <= 1'b0;
      overrun_flag_r         <= 1'b0;
      framing_error_flag_r   <= 1'b0;
      trigger_seen_r         <= 1'b0;
    end else begin
      if (rx_good) begin
        rx_data_holding_r <= rx_shift_reg_r;
      end
      if (wr_tx) begin
        tx_data_holding_r <= wb_dat_in[7:0];
      end
      if (wr_fmt) begin
        serial_format_select_r <= wb_dat_in[7:0];
      end
      if (wr_baud) begin
        baud_divisor_r <= wb_dat_in[7:0];
      end
      if (wr_ctl) begin
        serial_control_reg_r <= wb_dat_in[7:0];
      end
      if (wr_card) begin
        card_mode_reg_r <= wb_dat_in[7:0];
      end
      // Writing a one leaves a flag alone; no write can set one
      if (tx_load) begin
        tx_empty_flag_r <= 1'b1;
      end else if (wr_tx || (wr_flags && !wb_dat_in[FLG_TX_EMPTY])) begin
        tx_empty_flag_r <= 1'b0;
      end
      if (rx_good) begin
        rx_full_flag_r <= 1'b1;
      end else if (clr_rx_full) begin
        rx_full_flag_r <= 1'b0;
      end
      if (rx_over) begin
        overrun_flag_r <= 1'b1;
      end else if (wr_flags && !wb_dat_in[FLG_OVERRUN]) begin
        overrun_flag_r <= 1'b0;
      end
      if (rx_frame) begin
        framing_error_flag_r <= 1'b1;
      end else if (wr_flags && !wb_dat_in[FLG_FRAMING]) begin
        framing_error_flag_r <= 1'b0;
      end
      if (!rx_enable) begin
        trigger_seen_r <= 1'b0;
      end else if (start_trigger_pin_in) begin
        trigger_seen_r <= 1'b1;
      end
    end
  end

  assign rx_full_request_out  = rx_full_flag_r && serial_control_reg_r[CTL_RXI_EN];
  assign rx_error_request_out = (overrun_flag_r || framing_error_flag_r)
                                && serial_control_reg_r[CTL_ERI_EN];

  // ----------------------------------------------------------------
  // Transmitter: start, 8 data LSB first, stop
  // ----------------------------------------------------------------
  logic [9:0] tx_shift_reg_r;
  logic [3:0] tx_bit_r;
  logic [3:0] tx_tick_r;
  assign tx_idle = (tx_bit_r == 4'h0);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_shift_reg_r <= 10'h3FF;
      tx_bit_r       <= 4'h0;
      tx_tick_r      <= 4'h0;
    end else if (tx_load) begin
      tx_shift_reg_r <= {1'b1, tx_data_holding_r, 1'b0};
      tx_bit_r       <= TX_BITS;
      tx_tick_r      <= 4'h0;
    end else if (!tx_idle && baud_tick) begin
      tx_tick_r <= tx_tick_r + 4'h1;
      if (tx_tick_r == LAST_TICK) begin
        tx_shift_reg_r <= {1'b1, tx_shift_reg_r[9:1]};
        tx_bit_r       <= tx_bit_r - 4'h1;
      end
    end
  end

  assign serial_out_pin_out = tx_shift_reg_r[0];

endmodule

`default_nettype wire

// ===== logic/asr_pkg.sv
// Package: constants, register map and types of the serial receiver with DMA
package asr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned BAUD_BPS    = 38_400;
  localparam int unsigned OVERSAMPLE  = 16;
  localparam logic [7:0]  BAUD_RESET  = 8'((CLK_HZ / (OVERSAMPLE * BAUD_BPS)) - 1);
  localparam logic [3:0]  MID_TICK    = 4'h7;
  localparam logic [3:0]  LAST_TICK   = 4'hF;
  localparam logic [3:0]  DATA_BITS   = 4'h8;
  localparam logic [3:0]  TX_BITS     = 4'hA;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RX_DATA  = 8'h00;
  localparam logic [7:0] OFS_TX_DATA  = 8'h04;
  localparam logic [7:0] OFS_FORMAT   = 8'h08;
  localparam logic [7:0] OFS_BAUD     = 8'h0C;
  localparam logic [7:0] OFS_CONTROL  = 8'h10;
  localparam logic [7:0] OFS_FLAGS    = 8'h14;
  localparam logic [7:0] OFS_CARD     = 8'h18;
  localparam logic [7:0] OFS_DMA_SRC  = 8'h1C;
  localparam logic [7:0] OFS_DMA_DST  = 8'h20;
  localparam logic [7:0] OFS_DMA_CNT  = 8'h24;
  localparam logic [7:0] OFS_DMA_MODE = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_RX_EN   = 0;
  localparam int CTL_TX_EN   = 1;
  localparam int CTL_RXI_EN  = 2;
  localparam int CTL_ERI_EN  = 3;
  localparam int FLG_PARITY   = 3;
  localparam int FLG_FRAMING  = 4;
  localparam int FLG_OVERRUN  = 5;
  localparam int FLG_RX_FULL  = 6;
  localparam int FLG_TX_EMPTY = 7;
  localparam int CARD_SMART  = 0;
  localparam int FMT_PRESCALE_LO = 0;
  localparam int DMA_ENABLE  = 0;
  localparam int DMA_END     = 1;
  localparam logic [31:0] DMA_CNT_RESET = 32'h0000_0080;
  localparam logic [31:0] DMA_DST_STEP  = 32'h0000_0001;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_state_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [7:0]  data;
  } asr_dma_wr_t;

endpackage

// ===== dv/asr_serial_rx_dma_checker.sv
// Checker: port-level properties of the serial receiver with DMA
`timescale 1ns/1ps
`default_nettype none
module asr_serial_rx_dma_checker
  import asr_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        rx_full_request_out,
  input wire logic        rx_error_request_out,
  input wire logic        dma_end_out,
  input wire asr_dma_wr_t dma_wr_out
);
  logic [31:0] last_dst_r;
  logic        have_dst_r;
  // A software write to the pointer restarts the step check
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || (wb_ack_out && wb_we_in && wb_adr_in == OFS_DMA_DST)) begin
      have_dst_r <= 1'b0;
      last_dst_r <= 32'h0000_0000;
    end else if (dma_wr_out.valid) begin
      have_dst_r <= 1'b1;
      last_dst_r <= dma_wr_out.addr;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_ACK_LATENCY: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_RX_UPPER_ZERO: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in == OFS_RX_DATA |-> wb_dat_out[31:8] == 24'h00_0000)
    else $error("receive data wider than a byte");
  AST_PARITY_CLEAR: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in == OFS_FLAGS |-> !wb_dat_out[FLG_PARITY])
    else $error("parity flag set");
  AST_DMA_PULSE: assert property (dma_wr_out.valid |=> !dma_wr_out.valid)
    else $error("dma write longer than one cycle");
  AST_DMA_CAUSE: assert property (dma_wr_out.valid |-> $past(rx_full_request_out))
    else $error("dma write without receive-full request");
  AST_FULL_CLEARED: assert property (dma_wr_out.valid |-> ##[1:2] !rx_full_request_out)
    else $error("receive-full not cleared after dma");
  AST_DST_STEP: assert property (
    dma_wr_out.valid && have_dst_r |-> dma_wr_out.addr == last_dst_r + DMA_DST_STEP)
    else $error("dest step wrong");
  COV_DMA: cover property (dma_wr_out.valid);
  COV_END: cover property ($rose(dma_end_out));
  COV_ERR: cover property ($rose(rx_error_request_out));
endmodule
bind asr_serial_rx_dma asr_serial_rx_dma_checker chk_u (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .rx_full_request_out(rx_full_request_out), .rx_error_request_out(rx_error_request_out),
  .dma_end_out(dma_end_out), .dma_wr_out(dma_wr_out));
`default_nettype wire

// ===== dv/asr_remote_tx.sv
// Remote asynchronous transmitter with start trigger
`timescale 1ns/1ps
`default_nettype none
module asr_remote_tx #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       arm_in,
  input  wire logic       send_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       bad_stop_in,
  output var  logic       line_out,
  output var  logic       trigger_out,
  output var  logic       busy_out
);
  logic [9:0] sh_r;
  logic [3:0] bit_r;
  int         tick_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_out    <= 1'b1;
      trigger_out <= 1'b0;
      busy_out    <= 1'b0;
      bit_r       <= 4'h0;
      tick_r      <= 0;
      sh_r        <= 10'h3FF;
    end else begin
      trigger_out <= arm_in;
      if (send_in && !busy_out) begin
        // Stop, data LSB first, start; a bad stop is only for error tests
        sh_r     <= {~bad_stop_in, byte_in, 1'b0};
        line_out <= 1'b0;
        busy_out <= 1'b1;
        bit_r    <= 4'h0;
        tick_r   <= 0;
      end else if (busy_out) begin
        if (tick_r == BIT_CLKS - 1) begin
          tick_r <= 0;
          if (bit_r == 4'h9) begin
            busy_out <= 1'b0;
            line_out <= 1'b1;
          end else begin
            bit_r    <= bit_r + 4'h1;
            line_out <= sh_r[bit_r + 4'h1];
          end
        end else begin
          tick_r <= tick_r + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/asr_serial_rx_dma_test.sv
// Testbench: self-checking bench for the serial receiver with DMA
`timescale 1ns/1ps
`default_nettype none
module asr_serial_rx_dma_test;
  import asr_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, arm = 1'b0, send = 1'b0, bad = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00, sbyte = 8'h00, b0, t0, t1;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic        ack, sout, rxf, rxe, dend, line, trig, busy;
  asr_dma_wr_t dwr;
  int          bad_count = 0, tests_run = 0, exp_addr, n;
  logic [7:0]  exp_q[$];
  always #4 sys_clk_in = ~sys_clk_in;
  asr_serial_rx_dma dut_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack), .serial_in_pin_in(line),
    .start_trigger_pin_in(trig), .serial_out_pin_out(sout), .rx_full_request_out(rxf),
    .rx_error_request_out(rxe), .dma_end_out(dend), .dma_wr_out(dwr));
  asr_remote_tx #(.BIT_CLKS(16)) far_u (.clk_in(sys_clk_in), .rst_in(sys_rst_in),
    .arm_in(arm), .send_in(send), .byte_in(sbyte), .bad_stop_in(bad), .line_out(line),
    .trigger_out(trig), .busy_out(busy));
  task print_verdict;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single cycle; no latency assumed, bounded by the bench
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    k = 0;
    do begin @(posedge sys_clk_in); k++; end while (ack !== 1'b1 && k < 50);
    chk({31'h0, ack}, 32'h1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task send_b(input logic [7:0] b, input logic bs);
    int k;
    @(posedge sys_clk_in);
    sbyte <= b; bad <= bs; send <= 1'b1;
    @(posedge sys_clk_in);
    send <= 1'b0;
    k = 0;
    do begin @(posedge sys_clk_in); k++; end while (busy !== 1'b0 && k < 400);
    chk({31'h0, busy}, 32'h0);
  endtask
  task cap_tx(input logic [7:0] exp_b);
    int k;
    logic [9:0] f;
    k = 0;
    do begin @(posedge sys_clk_in); k++; end while (sout !== 1'b0 && k < 3000);
    repeat (8) @(posedge sys_clk_in);
    for (int i = 0; i < 10; i++) begin
      f[i] = sout;
      if (i < 9) repeat (16) @(posedge sys_clk_in);
    end
    chk({22'h0, f}, {22'h0, 1'b1, exp_b, 1'b0});
  endtask
  // Model of memory traffic: one byte per frame, rising destination
  always @(posedge sys_clk_in) begin
    if (dwr.valid === 1'b1) begin
      chk(dwr.addr, 32'(exp_addr));
      chk({24'h0, dwr.data}, {24'h0, exp_q.pop_front()});
      exp_addr++;
    end
  end
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    bad_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(79));
    repeat (10) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(OFS_BAUD, 32'h0000_00CA);
    rd_chk(OFS_DMA_CNT, DMA_CNT_RESET);
    rd_chk(8'h3C, 32'h0);
    wb(1'b1, OFS_RX_DATA, 32'h0000_00FF);
    rd_chk(OFS_RX_DATA, 32'h0);
    wb(1'b1, OFS_FLAGS, 32'h0000_00FF);
    rd_chk(OFS_FLAGS, 32'h0000_0080);
    wb(1'b1, OFS_BAUD, 32'h0);
    wb(1'b1, OFS_FORMAT, 32'h0);
    wb(1'b1, OFS_CARD, 32'h0);
    wb(1'b1, OFS_DMA_SRC, 32'h1234_5678);
    wb(1'b1, OFS_DMA_DST, 32'h0000_0100);
    wb(1'b1, OFS_DMA_CNT, 32'h0000_0080);
    wb(1'b1, OFS_DMA_MODE, 32'h0000_0001);
    wb(1'b1, OFS_CONTROL, 32'h0000_000F);
    exp_addr = 32'h100;
    // Traffic before the trigger must be ignored
    send_b(8'h5A, 1'b0);
    repeat (20) @(posedge sys_clk_in);
    rd_chk(OFS_FLAGS, 32'h0000_0080);
    arm <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    for (int i = 0; i < 128; i++) begin
      b0 = 8'($urandom);
      exp_q.push_back(b0);
      send_b(b0, 1'b0);
    end
    repeat (10) @(posedge sys_clk_in);
    chk(32'(exp_q.size()), 32'h0);
    rd_chk(OFS_DMA_CNT, 32'h0);
    rd_chk(OFS_DMA_DST, 32'h0000_0180);
    rd_chk(OFS_DMA_SRC, 32'h1234_5678);
    rd_chk(OFS_DMA_MODE, 32'h0000_0002);
    chk({31'h0, dend}, 32'h1);
    wb(1'b1, OFS_DMA_MODE, 32'h0);
    t0 = 8'($urandom);
    t1 = 8'($urandom);
    send_b(t0, 1'b0);
    send_b(t1, 1'b0);
    repeat (10) @(posedge sys_clk_in);
    rd_chk(OFS_RX_DATA, {24'h0, t0});
    rd_chk(OFS_FLAGS, 32'h0000_00E0);
    chk({30'h0, rxe, rxf}, 32'h3);
    wb(1'b1, OFS_FLAGS, 32'h0000_0080);
    rd_chk(OFS_FLAGS, 32'h0000_0080);
    send_b(8'h3C, 1'b1);
    repeat (10) @(posedge sys_clk_in);
    rd_chk(OFS_FLAGS, 32'h0000_0090);
    rd_chk(OFS_RX_DATA, {24'h0, t0});
    chk({30'h0, rxe, rxf}, 32'h2);
    wb(1'b1, OFS_CONTROL, 32'h0000_0002);
    @(posedge sys_clk_in);
    chk({30'h0, rxe, rxf}, 32'h0);
    wb(1'b1, OFS_FLAGS, 32'h0000_0080);
    // Second byte waits in the holding register behind the first
    fork
      begin
        cap_tx(t0);
        cap_tx(t1);
      end
      begin
        wb(1'b1, OFS_TX_DATA, {24'h0, t0});
        n = 0;
        do begin wb(1'b0, OFS_FLAGS, 32'h0); n++; end while (rdat[FLG_TX_EMPTY] !== 1'b1 && n < 50);
        wb(1'b1, OFS_TX_DATA, {24'h0, t1});
      end
    join
    print_verdict;
  end
endmodule
`default_nettype wire
